/* logic/sas_pkg.sv */
// Functional notes
// - A conversion sequence starts from the selected source: software command, timer one overflow, timer two overflow or the external start input.
// - Each sequence accumulates 1, 4, 8 or 16 samples, as programmed, before it counts as complete.
// - Completion always sets the done status bit, and raises the interrupt only while its enable bit is set.
// - The accumulated result, 12 to 16 bits wide, is latched into the data register when the sequence completes.
// - In burst mode the converter is powered up by the sequencer, samples, and is powered down again without software.
// - Each result is compared against programmable low and high limits, flagging either inside or outside the range.
// - A result that fails the selected window condition never sets the window flag.
// - Sample starts are spaced so that throughput reaches but never exceeds 200 ksps.
// - Software can hold the converter shut down through an enable bit independent of burst mode.
// - Software selects the positive input: port pins, temperature sensor or core supply.
package sas_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int SAMPLE_PERIOD_NS = 5000;
  localparam int RATE_CYCLES      = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_NS          = 1000;
  localparam int WAKE_CYCLES      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 6;
  localparam logic [5:0]  OFF_CTRL    = 6'h00;
  localparam logic [5:0]  OFF_MUX     = 6'h04;
  localparam logic [5:0]  OFF_CMD     = 6'h08;
  localparam logic [5:0]  OFF_DATA    = 6'h0C;
  localparam logic [5:0]  OFF_WIN_LO  = 6'h10;
  localparam logic [5:0]  OFF_WIN_HI  = 6'h14;
  localparam logic [5:0]  OFF_STATUS  = 6'h18;
  localparam logic [5:0]  OFF_INT_CLR = 6'h1C;
  localparam logic [5:0]  OFF_INT_EN  = 6'h20;
  localparam logic [5:0]  OFF_STATE   = 6'h24;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_BURST  = 1;
  localparam int          CTRL_SRC    = 2;
  localparam int          CTRL_ACC    = 4;
  localparam int          CTRL_WMODE  = 6;
  localparam int          CTRL_W      = 7;
  localparam int          CMD_START   = 0;
  localparam int          ST_DONE     = 0;
  localparam int          ST_WIN      = 1;
  localparam int          ST_W        = 2;
  localparam int          MUX_W       = 5;
  localparam int          RES_W       = 16;
  localparam int          SMP_W       = 12;
  localparam logic [1:0]  SRC_SW      = 2'h0;
  localparam logic [1:0]  SRC_T1      = 2'h1;
  localparam logic [1:0]  SRC_T2      = 2'h2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] WIN_HI_RST  = 16'hFFFF;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'h0,
    SAS_WAKE = 2'h1,
    SAS_GAP  = 2'h3,
    SAS_CONV = 2'h2
  } sas_state_e;

endpackage

/* logic/sas_sar_adc_sequencer.sv */
`timescale 1ns/1ps
module sas_sar_adc_sequencer (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write address
  input  wire logic [sas_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // axi4-lite read address
  input  wire logic [sas_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // start sources
  input  wire logic                           timer1_ovf,
  input  wire logic                           timer2_ovf,
  input  wire logic                           ext_start,
  // converter core
  output logic                                sar_power,
  output logic                                sar_start,
  output logic [sas_pkg::MUX_W-1:0]           sar_mux,
  input  wire logic                           sar_done,
  input  wire logic [sas_pkg::SMP_W-1:0]      sar_data,
  // interrupt
  output logic                                irq
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] word_of(input logic [sas_pkg::ADDR_W-1:0] a);
    return {a[5:2], 2'h0};
  endfunction

  function automatic logic [4:0] samples_of(input logic [1:0] code);
    case (code)
      2'h0:    return 5'h01;
      2'h1:    return 5'h04;
      2'h2:    return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int RATE_W = $clog2(sas_pkg::RATE_CYCLES + 1);
  localparam int WAKE_W = $clog2(sas_pkg::WAKE_CYCLES + 1);
  localparam int CTRL_W = sas_pkg::CTRL_W;
  localparam int MUX_W  = sas_pkg::MUX_W;

  logic [sas_pkg::CTRL_W-1:0] ctrl_ff;
  logic [sas_pkg::MUX_W-1:0]  mux_ff;
  logic [15:0]                win_lo_ff;
  logic [15:0]                win_hi_ff;
  logic [sas_pkg::ST_W-1:0]   inten_ff;
  logic [sas_pkg::ST_W-1:0]   status_ff;
  logic [sas_pkg::ST_W-1:0]   clr_ff;
  logic [sas_pkg::RES_W-1:0]  data_ff;
  logic                       cmd_start_ff;
  logic                       aw_held_ff;
  logic                       w_held_ff;
  logic [sas_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0]                wdata_ff;
  logic [3:0]                 wstrb_ff;
  logic [1:0]                 ext_sync_ff;
  logic                       ext_prev_ff;
  logic [1:0]                 done_sync_ff;
  logic                       done_prev_ff;
  logic [sas_pkg::SMP_W-1:0]  data_meta_ff;
  logic [sas_pkg::SMP_W-1:0]  data_sync_ff;
  sas_pkg::sas_state_e        state_ff;
  sas_pkg::sas_state_e        nxt_state;
  logic [RATE_W-1:0]          rate_cnt_ff;
  logic [WAKE_W-1:0]          wake_cnt_ff;
  logic [4:0]                 smp_cnt_ff;
  logic [sas_pkg::RES_W-1:0]  acc_ff;
  logic [sas_pkg::RES_W-1:0]  sum;
  logic                       trig;
  logic                       ext_rise;
  logic                       done_rise;
  logic                       launch;
  logic                       last;
  logic                       finish;
  logic                       in_win;
  logic                       win_hit;
  logic                       do_wr;
  logic                       wr_err;
  logic [31:0]                rd_data;
  logic                       rd_err;
  logic [sas_pkg::ST_W-1:0]   set_vec;

  wire en    = ctrl_ff[sas_pkg::CTRL_EN];
  wire burst = ctrl_ff[sas_pkg::CTRL_BURST];

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_ff  <= 2'h0;
      ext_prev_ff  <= 1'b0;
      done_sync_ff <= 2'h0;
      done_prev_ff <= 1'b0;
      data_meta_ff <= '0;
      data_sync_ff <= '0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[0], ext_start};
      ext_prev_ff  <= ext_sync_ff[1];
      done_sync_ff <= {done_sync_ff[0], sar_done};
      done_prev_ff <= done_sync_ff[1];
      data_meta_ff <= sar_data;
      data_sync_ff <= data_meta_ff;
    end
  end

  assign ext_rise  = ext_sync_ff[1] & ~ext_prev_ff;
  assign done_rise = done_sync_ff[1] & ~done_prev_ff;

  // ---------------------------------------------------------------
  // start source selection
  // ---------------------------------------------------------------
  always_comb begin
    case (ctrl_ff[sas_pkg::CTRL_SRC +: 2])
      sas_pkg::SRC_SW: trig = cmd_start_ff;
      sas_pkg::SRC_T1: trig = timer1_ovf;
      sas_pkg::SRC_T2: trig = timer2_ovf;
      default:         trig = ext_rise;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign sum     = acc_ff + {{(sas_pkg::RES_W-sas_pkg::SMP_W){1'b0}}, data_sync_ff};
  assign last    = (smp_cnt_ff + 5'h01) == samples_of(ctrl_ff[sas_pkg::CTRL_ACC +: 2]);
  assign finish  = (state_ff == sas_pkg::SAS_CONV) && done_rise && last && en;
  assign launch  = (state_ff == sas_pkg::SAS_GAP) && (nxt_state == sas_pkg::SAS_CONV);
  assign in_win  = (sum >= win_lo_ff) && (sum <= win_hi_ff);
  assign win_hit = ctrl_ff[sas_pkg::CTRL_WMODE] ? ~in_win : in_win;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sas_pkg::SAS_IDLE: begin
        if (en && trig) begin
          nxt_state = burst ? sas_pkg::SAS_WAKE : sas_pkg::SAS_GAP;
        end
      end
      sas_pkg::SAS_WAKE: begin
        if (wake_cnt_ff == '0) begin
          nxt_state = sas_pkg::SAS_GAP;
        end
      end
      sas_pkg::SAS_GAP: begin
        if (rate_cnt_ff == '0) begin
          nxt_state = sas_pkg::SAS_CONV;
        end
      end
      sas_pkg::SAS_CONV: begin
        if (done_rise) begin
          nxt_state = last ? sas_pkg::SAS_IDLE : sas_pkg::SAS_GAP;
        end
      end
      default: nxt_state = sas_pkg::SAS_IDLE;
    endcase
    if (!en) begin
      nxt_state = sas_pkg::SAS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= sas_pkg::SAS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_ff <= '0;
      wake_cnt_ff <= '0;
    end else begin
      if (launch) begin
        rate_cnt_ff <= RATE_W'(sas_pkg::RATE_CYCLES - 1);
      end else if (rate_cnt_ff != '0) begin
        rate_cnt_ff <= rate_cnt_ff - 1'b1;
      end
      if (state_ff == sas_pkg::SAS_IDLE && nxt_state == sas_pkg::SAS_WAKE) begin
        wake_cnt_ff <= WAKE_W'(sas_pkg::WAKE_CYCLES - 1);
      end else if (wake_cnt_ff != '0) begin
        wake_cnt_ff <= wake_cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff     <= '0;
      smp_cnt_ff <= 5'h00;
    end else if (state_ff == sas_pkg::SAS_IDLE) begin
      acc_ff     <= '0;
      smp_cnt_ff <= 5'h00;
    end else if (state_ff == sas_pkg::SAS_CONV && done_rise) begin
      acc_ff     <= sum;
      smp_cnt_ff <= smp_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ff <= '0;
    end else if (finish) begin
      data_ff <= sum;
    end
  end

  // ---------------------------------------------------------------
  // converter outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sar_power <= 1'b0;
      sar_start <= 1'b0;
      sar_mux   <= '0;
    end else begin
      sar_power <= en && (!burst || nxt_state != sas_pkg::SAS_IDLE);
      sar_start <= launch;
      sar_mux   <= mux_ff;
    end
  end

  // ---------------------------------------------------------------
  // status and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    set_vec                  = '0;
    set_vec[sas_pkg::ST_DONE] = finish;
    set_vec[sas_pkg::ST_WIN]  = finish && win_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      irq       <= 1'b0;
    end else begin
      status_ff <= (status_ff & ~clr_ff) | set_vec;
      irq       <= |(status_ff & inten_ff);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write
  // ---------------------------------------------------------------
  assign do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;

  always_comb begin
    case (word_of(awaddr_ff))
      sas_pkg::OFF_CTRL, sas_pkg::OFF_MUX, sas_pkg::OFF_CMD, sas_pkg::OFF_DATA, sas_pkg::OFF_WIN_LO,
      sas_pkg::OFF_WIN_HI, sas_pkg::OFF_STATUS, sas_pkg::OFF_INT_CLR, sas_pkg::OFF_INT_EN,
      sas_pkg::OFF_STATE: wr_err = 1'b0;
      default:            wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sas_pkg::RESP_OKAY;
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff     <= s_axi_awaddr;
        aw_held_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        w_held_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? sas_pkg::RESP_SLVERR : sas_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff      <= '0;
      mux_ff       <= '0;
      win_lo_ff    <= 16'h0000;
      win_hi_ff    <= sas_pkg::WIN_HI_RST;
      inten_ff     <= '0;
      clr_ff       <= '0;
      cmd_start_ff <= 1'b0;
    end else begin
      clr_ff       <= '0;
      cmd_start_ff <= 1'b0;
      if (do_wr) begin
        case (word_of(awaddr_ff))
          sas_pkg::OFF_CTRL:    ctrl_ff <= CTRL_W'(strb_merge(32'(ctrl_ff), wdata_ff, wstrb_ff));
          sas_pkg::OFF_MUX:     mux_ff <= MUX_W'(strb_merge(32'(mux_ff), wdata_ff, wstrb_ff));
          sas_pkg::OFF_CMD:     cmd_start_ff <= wstrb_ff[0] & wdata_ff[sas_pkg::CMD_START];
          sas_pkg::OFF_WIN_LO:  win_lo_ff <= 16'(strb_merge(32'(win_lo_ff), wdata_ff, wstrb_ff));
          sas_pkg::OFF_WIN_HI:  win_hi_ff <= 16'(strb_merge(32'(win_hi_ff), wdata_ff, wstrb_ff));
          sas_pkg::OFF_INT_CLR: clr_ff <= wstrb_ff[0] ? wdata_ff[sas_pkg::ST_W-1:0] : '0;
          sas_pkg::OFF_INT_EN:  inten_ff <= wstrb_ff[0] ? wdata_ff[sas_pkg::ST_W-1:0] : inten_ff;
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (word_of(s_axi_araddr))
      sas_pkg::OFF_CTRL:    rd_data = 32'(ctrl_ff);
      sas_pkg::OFF_MUX:     rd_data = 32'(mux_ff);
      sas_pkg::OFF_DATA:    rd_data = 32'(data_ff);
      sas_pkg::OFF_WIN_LO:  rd_data = 32'(win_lo_ff);
      sas_pkg::OFF_WIN_HI:  rd_data = 32'(win_hi_ff);
      sas_pkg::OFF_STATUS:  rd_data = 32'(status_ff);
      sas_pkg::OFF_INT_EN:  rd_data = 32'(inten_ff);
      sas_pkg::OFF_STATE:   rd_data = {29'h0, sar_power, (state_ff != sas_pkg::SAS_IDLE), irq};
      sas_pkg::OFF_CMD, sas_pkg::OFF_INT_CLR: rd_data = 32'h0000_0000;
      default:              rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sas_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_err ? sas_pkg::RESP_SLVERR : sas_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [RATE_W-1:0] since_start_ff;
  logic              started_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_start_ff <= '0;
      started_ff     <= 1'b0;
    end else if (sar_start) begin
      since_start_ff <= RATE_W'(1);
      started_ff     <= 1'b1;
    end else if (since_start_ff != '1) begin
      since_start_ff <= since_start_ff + 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_start_src;
    (state_ff == sas_pkg::SAS_IDLE) && en && trig |=> (state_ff != sas_pkg::SAS_IDLE);
  endproperty
  a_start_src: assert property (p_start_src) else $error("accepted trigger did not start a sequence");

  property p_count;
    finish |-> (smp_cnt_ff == samples_of(ctrl_ff[sas_pkg::CTRL_ACC +: 2]) - 5'h01);
  endproperty
  a_count: assert property (p_count) else $error("sequence completed with wrong sample count");

  property p_done_irq;
    finish |=> status_ff[sas_pkg::ST_DONE] ##1 (irq == inten_ff[sas_pkg::ST_DONE] || irq);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done status or interrupt missing");

  property p_latch;
    finish |=> (data_ff == $past(sum));
  endproperty
  a_latch: assert property (p_latch) else $error("result not latched at completion");

  property p_burst_off;
    burst && (state_ff == sas_pkg::SAS_IDLE) && (nxt_state == sas_pkg::SAS_IDLE) |=> !sar_power;
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("converter powered while idle in burst mode");

  property p_win_set;
    finish && win_hit |=> status_ff[sas_pkg::ST_WIN];
  endproperty
  a_win_set: assert property (p_win_set) else $error("window flag missed a matching result");

  property p_win_hold;
    finish && !win_hit && !status_ff[sas_pkg::ST_WIN] |=> !status_ff[sas_pkg::ST_WIN];
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window flag set by failing result");

  property p_rate;
    sar_start && started_ff |-> ##0 (since_start_ff >= RATE_W'(sas_pkg::RATE_CYCLES));
  endproperty
  a_rate: assert property (p_rate) else $error("samples started faster than allowed");

  property p_shutdown;
    !en |=> !sar_power && !sar_start;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("converter active while disabled");

  property p_busy;
    (state_ff == sas_pkg::SAS_CONV) && en && trig && !done_rise |=> (state_ff == sas_pkg::SAS_CONV);
  endproperty
  a_busy: assert property (p_busy) else $error("trigger disturbed a running sequence");

endmodule // sas_sar_adc_sequencer

/* tb/sas_sar_model.sv */
`timescale 1ns/1ps
module sas_sar_model (
  // clock
  input  wire logic        aclk,
  // converter control
  input  wire logic        sar_power,
  input  wire logic        sar_start,
  input  wire logic [11:0] smp,
  // converter answer
  output logic             sar_done,
  output logic [11:0]      sar_data
);
  // ---------------------------------------------------------------
  // one sample: done high six cycles, data stable around it
  // ---------------------------------------------------------------
  logic [3:0] cnt_ff = 4'h0;

  always_ff @(posedge aclk) begin
    if (sar_start && sar_power)
      cnt_ff <= 4'h1;
    else if (cnt_ff != 4'h0)
      cnt_ff <= (cnt_ff == 4'hA) ? 4'h0 : cnt_ff + 4'h1;
  end

  assign sar_done = (cnt_ff >= 4'h5);
  assign sar_data = (cnt_ff >= 4'h3) ? smp : ~smp;
endmodule // sas_sar_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct {logic [6:0] ctrl; logic [15:0] data;} sas_row_s;
  sas_row_s    rows[4] = '{'{7'h01, 16'h0ABC}, '{7'h15, 16'h2AF0}, '{7'h29, 16'h55E0}, '{7'h3D, 16'hABC0}};
  logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic        t1 = 1'h0, t2 = 1'h0, ext = 1'h0, hit;
  logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, sar_power, sar_start, sar_done, irq;
  logic [4:0]  sar_mux;
  logic [11:0] sar_data;
  int          bad_count = 0, checked = 0, cyc = 0, last = -1000, gapmin = 9999, starts = 0, s0;

  always #12.5 aclk = ~aclk;

  sas_sar_adc_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer1_ovf(t1), .timer2_ovf(t2), .ext_start(ext),
    .sar_power(sar_power), .sar_start(sar_start), .sar_mux(sar_mux), .sar_done(sar_done),
    .sar_data(sar_data), .irq(irq));
  sas_sar_model pm (.aclk(aclk), .sar_power(sar_power), .sar_start(sar_start), .smp(12'hABC),
    .sar_done(sar_done), .sar_data(sar_data));

  always @(posedge aclk) begin
    cyc++;
    if (sar_start === 1'h1) begin
      if (cyc - last < gapmin) gapmin = cyc - last;
      last = cyc;
      starts++;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awv <= 1'h1; wv <= 1'h1; bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'h0;
      if (wv && wready) wv <= 1'h0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arv <= 1'h1; rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arv && arready) arv <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  task automatic trig(input logic [1:0] s);
    if (s == 2'h0) wr(sas_pkg::OFF_CMD, 32'h1, r);
    else begin
      @(posedge aclk);
      if (s == 2'h1) t1 <= 1'h1; else if (s == 2'h2) t2 <= 1'h1; else ext <= 1'h1;
      @(posedge aclk);
      t1 <= 1'h0; t2 <= 1'h0;
      repeat (5) @(posedge aclk);
      ext <= 1'h0;
    end
  endtask

  task automatic wait_irq(input int lim, output logic h);
    h = 1'h0;
    repeat (lim) begin
      @(posedge aclk);
      if (irq === 1'h1) begin h = 1'h1; break; end
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(sas_pkg::OFF_WIN_HI, v, r); chk("win_hi reset", v, 32'hFFFF);
    rd(sas_pkg::OFF_CTRL, v, r); chk("ctrl reset", v, 32'h0);
    wr(sas_pkg::OFF_MUX, 32'h15, r); repeat (2) @(posedge aclk);
    chk("sar_mux", sar_mux, 32'h15);
    wr(sas_pkg::OFF_INT_EN, 32'h1, r);
    foreach (rows[i]) begin
      wr(sas_pkg::OFF_CTRL, rows[i].ctrl, r);
      trig(rows[i].ctrl[3:2]);
      wait_irq(4000, hit); chk("irq done", hit, 32'h1);
      rd(sas_pkg::OFF_STATUS, v, r); chk("status", v, 32'h3);
      rd(sas_pkg::OFF_DATA, v, r); chk("data", v, rows[i].data);
      wr(sas_pkg::OFF_INT_CLR, 32'h3, r); repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 32'h0);
      $display("test row %0d done", i);
    end
    wr(sas_pkg::OFF_WIN_HI, 32'h100, r);
    for (int m = 0; m < 2; m++) begin
      wr(sas_pkg::OFF_CTRL, 32'h1 | (m << 6), r); trig(2'h0); wait_irq(600, hit);
      rd(sas_pkg::OFF_STATUS, v, r); chk("window", v, m ? 32'h3 : 32'h1);
      wr(sas_pkg::OFF_INT_CLR, 32'h3, r);
    end
    $display("test window done");
    wr(sas_pkg::OFF_CTRL, 32'h3, r); trig(2'h0); repeat (2) @(posedge aclk);
    chk("burst wake", sar_power, 32'h1);
    wait_irq(600, hit); chk("burst sleep", sar_power, 32'h0);
    wr(sas_pkg::OFF_INT_CLR, 32'h3, r);
    wr(sas_pkg::OFF_CTRL, 32'h0, r); trig(2'h0); wait_irq(600, hit);
    chk("shutdown idle", hit, 32'h0);
    chk("shutdown power", sar_power, 32'h0);
    $display("test burst and shutdown done");
    wr(sas_pkg::OFF_CTRL, 32'h11, r); s0 = starts;
    trig(2'h0); trig(2'h0); wait_irq(1500, hit); repeat (600) @(posedge aclk);
    chk("starts", starts - s0, 32'h4);
    chk("spacing", gapmin >= 200, 32'h1);
    rd(6'h28, v, r); chk("unmapped rresp", r, 32'h2);
    wr(6'h28, 32'h1, r); chk("unmapped bresp", r, 32'h2);
    $display("test busy and unmapped done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk("reset power", sar_power, 32'h0);
    chk("reset irq", irq, 32'h0);
    rd(sas_pkg::OFF_CTRL, v, r); chk("ctrl after reset", v, 32'h0);
    rd(sas_pkg::OFF_STATUS, v, r); chk("status after reset", v, 32'h0);
    $display("test reset done");
    report_and_stop;
  end
endmodule // tb
